// file: src/wold_consts.svh
`ifndef WOLD_CONSTS_SVH
`define WOLD_CONSTS_SVH
// sizes
`define WOLD_NFILT 32
`define WOLD_FIDXW 5
`define WOLD_MASKW 128
`define WOLD_MIDXW 7
`define WOLD_MWRDS 4
`define WOLD_AW 12
`define WOLD_POSW 11
`define WOLD_DA_BYTES 6
`define WOLD_NCAUSE 6
`define WOLD_CRC_PRESET 16'hFFFF
// register byte offsets
`define WOLD_OFF_PMC 12'h000
`define WOLD_OFF_WCS1 12'h004
`define WOLD_OFF_WCS2 12'h008
`define WOLD_OFF_SRC 12'h00C
`define WOLD_OFF_STALO 12'h010
`define WOLD_OFF_STAHI 12'h014
// filter regions: config 0x100 + 4*n, masks 0x200 + 16*n + 4*k
`define WOLD_CFG_SEL 11:7
`define WOLD_CFG_REGION 5'h02
`define WOLD_CFG_IDX 6:2
`define WOLD_MASK_SEL 11:9
`define WOLD_MASK_REGION 3'h1
`define WOLD_MASK_FILT 8:4
`define WOLD_MASK_WORD 3:2
// power_mgmt_control fields
`define WOLD_PMC_WOL 0
`define WOLD_PMC_RCS 1
`define WOLD_PMC_RCE 2
`define WOLD_PMC_SUSP 5:4
`define WOLD_PMC_RWK 8
`define WOLD_SUSP_NONE 2'h0
`define WOLD_SUSP_THREE 2'h3
// control/status register fields
`define WOLD_WCS1_EN 3:0
`define WOLD_WCS1_STS 11:8
`define WOLD_WCS2_EN 1:0
`define WOLD_WCS2_STS 9:8
// cause bit positions
`define WOLD_C_EXACT 0
`define WOLD_C_PAT 1
`define WOLD_C_W1 3:0
`define WOLD_C_W2 5:4
// wake_source_record fields
`define WOLD_SRC_CAUSE 5:0
`define WOLD_SRC_FILT 12:8
// pattern_filter_config fields
`define WOLD_CFG_EN 31
`define WOLD_CFG_TYPE 25:24
`define WOLD_CFG_OFS 23:16
`define WOLD_CFG_CRC 15:0
// bus responses
`define WOLD_RESP_OKAY 2'h0
`define WOLD_RESP_SLVERR 2'h2
`endif

// file: src/wold_pkg.sv
`include "wold_consts.svh"
`default_nettype none
package wold_pkg;
    typedef logic [`WOLD_AW-1:0] wold_addr_t;
    typedef logic [7:0]          wold_byte_t;
    typedef enum logic [1:0] {wold_idle, wold_armed, wold_waking} wold_fsm_e;
    typedef struct packed {
        wold_fsm_e                                st;
        logic                                     lan_wake_global_enable;
        logic                                     rcs;
        logic                                     rce;
        logic [1:0]                               susp;
        logic [3:0]                               en1;
        logic [3:0]                               sts1;
        logic [1:0]                               en2;
        logic [1:0]                               sts2;
        logic [15:0]                              src;
        logic [31:0]                              sta_lo;
        logic [15:0]                              sta_hi;
        logic [`WOLD_NFILT-1:0][31:0]             cfg;
        logic [`WOLD_NFILT-1:0][`WOLD_MASKW-1:0]  mask;
        logic [`WOLD_NFILT-1:0][15:0]             crc;
        logic [`WOLD_POSW-1:0]                    pos;
        logic [`WOLD_DA_BYTES-1:0][7:0]           da;
        logic                                     rwk;
        logic                                     hold;
        logic                                     store;
        logic                                     awrdy;
        logic                                     wrdy;
        logic                                     awh;
        logic                                     wh;
        wold_addr_t                               awaddr;
        logic [31:0]                              wdata;
        logic [3:0]                               wstrb;
        logic                                     bvalid;
        logic [1:0]                               bresp;
        logic                                     arrdy;
        logic                                     rvalid;
        logic [31:0]                              rdata;
        logic [1:0]                               rresp;
    } wold_state_s;
endpackage : wold_pkg
`default_nettype wire

// file: src/wold_top.sv
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`include "wold_consts.svh"
`default_nettype none
module wold_top (
    // clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // register bus write
    input  wire wold_pkg::wold_addr_t awaddr,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire logic [31:0]        wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    output logic [1:0]              bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    // register bus read
    input  wire wold_pkg::wold_addr_t araddr,
    input  wire logic               arvalid,
    output logic                    arready,
    output logic [31:0]             rdata,
    output logic [1:0]              rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    // receive byte stream
    input  wire logic               rx_valid,
    input  wire logic               rx_sof,
    input  wire logic               rx_eof,
    input  wire wold_pkg::wold_byte_t rx_data,
    input  wire logic               rx_good,
    input  wire logic               rx_pass_filter,
    // other detectors, valid with rx_eof
    input  wire logic               rx_magic_hit,
    input  wire logic               rx_v4_syn_hit,
    input  wire logic               rx_v6_syn_hit,
    // host resume signaling
    input  wire logic               host_resume,
    // power outputs
    output logic                    rx_hold_normal,
    output logic                    rx_store_frame,
    output logic                    remote_wakeup
);
    import wold_pkg::*;

    wold_state_s q;
    wold_state_s d;

    logic [`WOLD_POSW-1:0]   bp;
    logic [`WOLD_NFILT-1:0]  sel;
    logic [`WOLD_NFILT-1:0]  fmatch;
    logic [15:0]             crc_nx [`WOLD_NFILT];
    logic                    armed;
    logic                    active;
    logic                    eof;
    logic                    own;
    logic                    mcast;
    logic                    bcast;
    logic [`WOLD_NCAUSE-1:0] det;
    logic [`WOLD_NCAUSE-1:0] hit;
    logic                    wake;
    logic                    w_do;
    logic                    w_cfg;
    logic                    w_msk;
    logic                    r_cfg;
    logic                    r_msk;
    logic [31:0]             pmc_word;
    logic [31:0]             wcs1_word;
    logic [31:0]             wcs2_word;
    logic [`WOLD_DA_BYTES-1:0][7:0] da_nx;

    // byte-lane merge of a write into an old word
    function automatic logic [31:0] wold_merge(input logic [31:0] o,
                                               input logic [31:0] n,
                                               input logic [3:0]  s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++)
        begin
            if (s[i])
            begin
                r[8*i +: 8] = n[8*i +: 8];
            end
        end
        return r;
    endfunction

    // one byte of the masked crc-16
    function automatic logic [15:0] wold_crc_step(input logic [15:0] c,
                                                  input logic [7:0]  b);
        logic [7:0] f;
        f[0] = c[15] ^ b[0];
        for (int i = 1; i < 8; i++)
        begin
            f[i] = c[15-i] ^ f[i-1] ^ b[i];
        end
        return {c[7] ^ f[7], c[6:2], c[1] ^ f[0], c[0] ^ f[1],
                f[0] ^ f[2], f[1] ^ f[3], f[2] ^ f[4], f[3] ^ f[5],
                f[4] ^ f[6], f[5] ^ f[7], f[6], f[7]};
    endfunction

    // frame position and address classes
    assign bp    = rx_sof ? '0 : q.pos;
    assign eof   = rx_valid && rx_eof;
    assign armed = q.st != wold_idle;
    assign active = armed && q.lan_wake_global_enable;
    assign own   = da_nx == {q.sta_hi, q.sta_lo};
    assign mcast = da_nx[0][0];
    assign bcast = &da_nx;

    // address with the byte now on the bus, so a six byte frame is judged whole
    always_comb
    begin
        da_nx = q.da;
        if (rx_valid && (bp < `WOLD_DA_BYTES))
        begin
            da_nx[bp[2:0]] = rx_data;
        end
    end

    // per-filter byte selection, crc and verdict
    generate
        for (genvar n = 0; n < `WOLD_NFILT; n++)
        begin : g_filt
            logic [15:0]             crc_in;
            logic [`WOLD_POSW-1:0]   ofs;
            logic [`WOLD_POSW-1:0]   rel;
            logic [`WOLD_MASKW-1:0]  mflat;
            logic [1:0]              typ;
            assign crc_in = rx_sof ? `WOLD_CRC_PRESET : q.crc[n];
            assign ofs    = `WOLD_POSW'(q.cfg[n][`WOLD_CFG_OFS]);
            assign rel    = bp - ofs;
            assign mflat  = q.mask[n];
            assign sel[n] = rx_valid && (bp >= ofs) && (rel < `WOLD_MASKW)
                            && mflat[rel[`WOLD_MIDXW-1:0]];
            assign crc_nx[n] = sel[n] ? wold_crc_step(crc_in, rx_data) : crc_in;
            assign typ    = q.cfg[n][`WOLD_CFG_TYPE];
            assign fmatch[n] = q.cfg[n][`WOLD_CFG_EN]
                               && (crc_nx[n] == q.cfg[n][`WOLD_CFG_CRC])
                               && rx_pass_filter
                               && (typ[0] || (typ[1] ? mcast : !mcast));
        end
    endgenerate

    // enabled causes seen at the end of a frame; the exact, pattern and broadcast causes also need rx_good
    assign det  = {rx_v4_syn_hit, rx_v6_syn_hit, bcast && rx_good, rx_magic_hit,
                   (|fmatch) && rx_good, own && rx_good};
    assign hit  = (eof && active) ? (det & {q.en2, q.en1}) : '0;
    assign wake = |hit;

    // bus decode and readable words
    assign w_do  = q.awh && q.wh && !q.bvalid;
    assign w_cfg = q.awaddr[`WOLD_CFG_SEL] == `WOLD_CFG_REGION;
    assign w_msk = q.awaddr[`WOLD_MASK_SEL] == `WOLD_MASK_REGION;
    assign r_cfg = araddr[`WOLD_CFG_SEL] == `WOLD_CFG_REGION;
    assign r_msk = araddr[`WOLD_MASK_SEL] == `WOLD_MASK_REGION;
    always_comb
    begin
        pmc_word = '0;
        pmc_word[`WOLD_PMC_WOL]  = q.lan_wake_global_enable;
        pmc_word[`WOLD_PMC_RCS]  = q.rcs;
        pmc_word[`WOLD_PMC_RCE]  = q.rce;
        pmc_word[`WOLD_PMC_SUSP] = q.susp;
        pmc_word[`WOLD_PMC_RWK]  = q.rwk;
        wcs1_word = '0;
        wcs1_word[`WOLD_WCS1_EN]  = q.en1;
        wcs1_word[`WOLD_WCS1_STS] = q.sts1;
        wcs2_word = '0;
        wcs2_word[`WOLD_WCS2_EN]  = q.en2;
        wcs2_word[`WOLD_WCS2_STS] = q.sts2;
    end

    // next state of the whole block
    always_comb
    begin
        logic [31:0]             m;
        logic [31:0]             c;
        logic [31:0]             rd;
        logic [1:0]              rr;
        logic [`WOLD_FIDXW-1:0]  fidx;
        d    = q;
        m    = wold_merge(32'h0000_0000, q.wdata, q.wstrb);
        c    = m;
        rd   = '0;
        rr   = `WOLD_RESP_OKAY;
        fidx = '0;
        d.store = 1'b0;
        // write channels are held until both are in
        if (awvalid && q.awrdy)
        begin
            d.awh    = 1'b1;
            d.awaddr = awaddr;
        end
        if (wvalid && q.wrdy)
        begin
            d.wh    = 1'b1;
            d.wdata = wdata;
            d.wstrb = wstrb;
        end
        if (bready && q.bvalid)
        begin
            d.bvalid = 1'b0;
        end
        // register write, status bits clear on written ones
        if (w_do)
        begin
            d.awh    = 1'b0;
            d.wh     = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = `WOLD_RESP_OKAY;
            if (q.awaddr == `WOLD_OFF_PMC)
            begin
                m = wold_merge(pmc_word, q.wdata, q.wstrb);
                d.lan_wake_global_enable = m[`WOLD_PMC_WOL];
                d.rcs    = m[`WOLD_PMC_RCS];
                d.rce    = m[`WOLD_PMC_RCE];
                d.susp   = m[`WOLD_PMC_SUSP];
            end
            else if (q.awaddr == `WOLD_OFF_WCS1)
            begin
                m = wold_merge(wcs1_word, q.wdata, q.wstrb);
                d.en1  = m[`WOLD_WCS1_EN];
                d.sts1 = q.sts1 & ~c[`WOLD_WCS1_STS];
            end
            else if (q.awaddr == `WOLD_OFF_WCS2)
            begin
                m = wold_merge(wcs2_word, q.wdata, q.wstrb);
                d.en2  = m[`WOLD_WCS2_EN];
                d.sts2 = q.sts2 & ~c[`WOLD_WCS2_STS];
            end
            else if (q.awaddr == `WOLD_OFF_SRC)
            begin
                d.src = q.src & ~c[15:0];
            end
            else if (q.awaddr == `WOLD_OFF_STALO)
            begin
                d.sta_lo = wold_merge(q.sta_lo, q.wdata, q.wstrb);
            end
            else if (q.awaddr == `WOLD_OFF_STAHI)
            begin
                m = wold_merge({16'h0000, q.sta_hi}, q.wdata, q.wstrb);
                d.sta_hi = m[15:0];
            end
            else if (w_cfg)
            begin
                d.cfg[q.awaddr[`WOLD_CFG_IDX]] =
                    wold_merge(q.cfg[q.awaddr[`WOLD_CFG_IDX]], q.wdata, q.wstrb);
            end
            else if (w_msk)
            begin
                d.mask[q.awaddr[`WOLD_MASK_FILT]][32*q.awaddr[`WOLD_MASK_WORD] +: 32] =
                    wold_merge(q.mask[q.awaddr[`WOLD_MASK_FILT]]
                               [32*q.awaddr[`WOLD_MASK_WORD] +: 32], q.wdata, q.wstrb);
            end
            else
            begin
                d.bresp = `WOLD_RESP_SLVERR;
            end
        end
        // suspend entry and exit by software
        case (q.st)
            wold_idle:
            begin
                if (d.susp != `WOLD_SUSP_NONE)
                begin
                    d.st = wold_armed;
                end
            end
            wold_armed:
            begin
                if (d.susp == `WOLD_SUSP_NONE)
                begin
                    d.st = wold_idle;
                end
            end
            wold_waking:
            begin
                d.st = wold_waking;
            end
            default:
            begin
                d.st = wold_idle;
            end
        endcase
        // resume signaling: optional clears, then normal state
        if (host_resume && armed)
        begin
            if (q.rcs)
            begin
                d.sts1 = '0;
                d.sts2 = '0;
            end
            if (q.rce)
            begin
                d.en1 = '0;
                d.en2 = '0;
            end
            d.susp = `WOLD_SUSP_NONE;
            d.st   = wold_idle;
            d.rwk  = 1'b0;
        end
        // receive bytes: position, address capture, crc
        if (rx_valid)
        begin
            d.pos = (&bp) ? bp : bp + 1'b1;
            d.da  = da_nx;
            for (int k = 0; k < `WOLD_NFILT; k++)
            begin
                d.crc[k] = crc_nx[k];
            end
        end
        // lowest matching filter is recorded
        for (int k = `WOLD_NFILT - 1; k >= 0; k--)
        begin
            if (fmatch[k])
            begin
                fidx = `WOLD_FIDXW'(k);
            end
        end
        // wake event: sticky flags, set beats clear
        if (wake)
        begin
            d.sts1 = d.sts1 | hit[`WOLD_C_W1];
            d.sts2 = d.sts2 | hit[`WOLD_C_W2];
            d.src[`WOLD_SRC_CAUSE] = d.src[`WOLD_SRC_CAUSE] | hit;
            if (hit[`WOLD_C_PAT])
            begin
                d.src[`WOLD_SRC_FILT] = fidx;
            end
            d.st    = wold_waking;
            d.rwk   = 1'b1;
            d.store = q.susp == `WOLD_SUSP_THREE;
        end
        // normal reception blocked while any enable stands
        d.hold = (|d.en1) || (|d.en2);
        // register read
        if (arvalid && q.arrdy)
        begin
            if (araddr == `WOLD_OFF_PMC)
            begin
                rd = pmc_word;
            end
            else if (araddr == `WOLD_OFF_WCS1)
            begin
                rd = wcs1_word;
            end
            else if (araddr == `WOLD_OFF_WCS2)
            begin
                rd = wcs2_word;
            end
            else if (araddr == `WOLD_OFF_SRC)
            begin
                rd = {16'h0000, q.src};
            end
            else if (araddr == `WOLD_OFF_STALO)
            begin
                rd = q.sta_lo;
            end
            else if (araddr == `WOLD_OFF_STAHI)
            begin
                rd = {16'h0000, q.sta_hi};
            end
            else if (r_cfg)
            begin
                rd = q.cfg[araddr[`WOLD_CFG_IDX]];
            end
            else if (r_msk)
            begin
                rd = q.mask[araddr[`WOLD_MASK_FILT]][32*araddr[`WOLD_MASK_WORD] +: 32];
            end
            else
            begin
                rr = `WOLD_RESP_SLVERR;
            end
            d.rvalid = 1'b1;
            d.rdata  = rd;
            d.rresp  = rr;
        end
        else if (rready && q.rvalid)
        begin
            d.rvalid = 1'b0;
        end
        d.awrdy = !d.awh && !d.bvalid;
        d.wrdy  = !d.wh && !d.bvalid;
        d.arrdy = !d.rvalid;
    end

    // state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // outputs straight from flops
    assign awready        = q.awrdy;
    assign wready         = q.wrdy;
    assign bvalid         = q.bvalid;
    assign bresp          = q.bresp;
    assign arready        = q.arrdy;
    assign rvalid         = q.rvalid;
    assign rdata          = q.rdata;
    assign rresp          = q.rresp;
    assign rx_hold_normal = q.hold;
    assign rx_store_frame = q.store;
    assign remote_wakeup  = q.rwk;

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wake;
        wake && (q.st == wold_armed);
    endsequence
    sequence s_resume;
        host_resume && armed && !w_do;
    endsequence

    property p_wake_signal;
        s_wake |=> remote_wakeup && (q.st == wold_waking);
    endproperty
    a_wake_signal: assert property (p_wake_signal)
        else $error("wake event did not raise remote wakeup");

    property p_store;
        wake && (q.susp == `WOLD_SUSP_THREE) |=> rx_store_frame ##1 !rx_store_frame;
    endproperty
    a_store: assert property (p_store)
        else $error("deep suspend wake frame not stored");

    property p_res_sts;
        (s_resume and (q.rcs && !wake)) |=> (q.sts1 == '0) && (q.sts2 == '0);
    endproperty
    a_res_sts: assert property (p_res_sts)
        else $error("resume left status bits set");

    property p_res_en;
        (s_resume and q.rce) |=> (q.en1 == '0) && (q.en2 == '0) && !rx_hold_normal;
    endproperty
    a_res_en: assert property (p_res_en)
        else $error("resume left enable bits set");

    property p_res_norm;
        (s_resume and !wake) |=> (q.st == wold_idle) && !remote_wakeup
                              && (q.susp == `WOLD_SUSP_NONE);
    endproperty
    a_res_norm: assert property (p_res_norm)
        else $error("resume did not return to normal");

    property p_src_keep;
        (s_resume and !wake) |=> $stable(q.src);
    endproperty
    a_src_keep: assert property (p_src_keep)
        else $error("wake source lost on resume");

    property p_exact;
        eof && active && q.en1[`WOLD_C_EXACT] && own && rx_good
            |=> q.sts1[`WOLD_C_EXACT] && remote_wakeup;
    endproperty
    a_exact: assert property (p_exact)
        else $error("exact address match not flagged");

    property p_block;
        ((|q.en1) || (|q.en2)) |-> rx_hold_normal;
    endproperty
    a_block: assert property (p_block)
        else $error("normal reception open with enable set");

    property p_crc_preset;
        rx_valid && rx_sof && !sel[0] |=> q.crc[0] == `WOLD_CRC_PRESET;
    endproperty
    a_crc_preset: assert property (p_crc_preset)
        else $error("crc not preset at frame start");

    property p_pattern;
        eof && active && q.en1[`WOLD_C_PAT] && (fmatch[1:0] == 2'h2) && rx_good
            |=> q.sts1[`WOLD_C_PAT] && (q.src[`WOLD_SRC_FILT] == 5'h1);
    endproperty
    a_pattern: assert property (p_pattern)
        else $error("pattern match not flagged");

    property p_sticky;
        q.sts1[`WOLD_C_PAT] && !w_do && !(host_resume && armed && q.rcs)
            |=> q.sts1[`WOLD_C_PAT];
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("status flag dropped without clear");

endmodule // wold_top
`default_nettype wire

// file: bench/wold_partner.sv
`default_nettype none
// receive path model: one byte per clock from start to end of frame
module wold_partner (
    // clock
    input  wire logic  aclk,
    // byte stream
    output logic       rx_valid,
    output logic       rx_sof,
    output logic       rx_eof,
    output logic [7:0] rx_data,
    // frame verdicts
    output logic       rx_good,
    output logic       rx_pass_filter,
    output logic       rx_magic_hit,
    output logic       rx_v4_syn_hit,
    output logic       rx_v6_syn_hit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] byte_q = 8'h00;
    // between frames the data lines show the inverse of the last byte
    assign rx_data = rx_valid ? byte_q : ~byte_q;
    assign rx_good = 1'b1;
    assign rx_pass_filter = 1'b1;
    assign rx_magic_hit = 1'b0;
    assign rx_v4_syn_hit = 1'b0;
    assign rx_v6_syn_hit = 1'b0;
    initial
    begin
        rx_valid = 1'b0;
        rx_sof = 1'b0;
        rx_eof = 1'b0;
    end
    // six byte frame, first byte sent first
    task automatic send(input logic [47:0] da);
        for (int i = 0; i < 6; i++)
        begin
            @(posedge aclk);
            rx_valid <= 1'b1;
            rx_sof <= (i == 0);
            rx_eof <= (i == 5);
            byte_q <= da[8*i+:8];
        end
        @(posedge aclk);
        rx_valid <= 1'b0;
        rx_eof <= 1'b0;
    endtask
endmodule : wold_partner
`default_nettype wire

// file: bench/wold_top_tb_top.sv
`default_nettype none
module wold_top_tb_top;
    import wold_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, host_resume;
    logic awready, wready, bvalid, arready, rvalid, rx_hold_normal, rx_store_frame;
    logic rx_valid, rx_sof, rx_eof, rx_good, rx_pass_filter, remote_wakeup;
    logic rx_magic_hit, rx_v4_syn_hit, rx_v6_syn_hit, stored;
    wold_addr_t awaddr, araddr;
    wold_byte_t rx_data;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int n_fail, total_checks;
    wold_top wold_top_inst (.*);
    wold_partner wold_partner_inst (.*);
    // clock
    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // remembers a store pulse
    always @(posedge aclk) if (rx_store_frame) stored <= 1'b1;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bready && bvalid)
            begin
                bready <= 1'b0;
                chk(bresp, 32'h0000_0000);
            end
        end
        while (awvalid || wvalid || bready);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rready && rvalid)
            begin
                rready <= 1'b0;
                chk(rdata, e);
                chk(rresp, r);
            end
        end
        while (rready);
    endtask
    task automatic wake_wait;
        for (int t = 0; t < 20 && remote_wakeup !== 1'b1; t++) @(posedge aclk);
        chk(remote_wakeup, 1);
    endtask
    task automatic resume;
        host_resume <= 1'b1;
        @(posedge aclk);
        host_resume <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
        logic [7:0] f;
        f[0] = c[15] ^ d[0];
        for (int i = 1; i < 8; i++) f[i] = c[15-i] ^ f[i-1] ^ d[i];
        return {c[7]^f[7], c[6:2], c[1]^f[0], c[0]^f[1], f[0]^f[2], f[1]^f[3],
                f[2]^f[4], f[3]^f[5], f[4]^f[6], f[5]^f[7], f[6], f[7]};
    endfunction
    task automatic t_reset;
        rd(12'h000, 0, 2'h0);
        rd(12'h004, 0, 2'h0);
        rd(12'h400, 0, 2'h2);
    endtask
    // exact address wake in deepest suspend, resume clears status and enables
    task automatic t_exact;
        wr(12'h010, 32'h4433_2211);
        wr(12'h014, 32'h0000_6655);
        wr(12'h004, 32'h0000_0001);
        wr(12'h000, 32'h0000_0037);
        chk(rx_hold_normal, 1);
        wold_partner_inst.send(48'h6655_4433_2211);
        wake_wait();
        @(posedge aclk);
        chk(stored, 1);
        rd(12'h004, 32'h0000_0101, 2'h0);
        rd(12'h00C, 32'h0000_0001, 2'h0);
        resume();
        chk(remote_wakeup, 0);
        chk(rx_hold_normal, 0);
        rd(12'h004, 0, 2'h0);
        rd(12'h00C, 32'h0000_0001, 2'h0);
        rd(12'h000, 32'h0000_0007, 2'h0);
        wr(12'h00C, 32'h0000_003F);
    endtask
    // pattern filter: mismatching frame ignored, matching one wakes
    task automatic t_pattern;
        wr(12'h210, 32'h0000_0001);
        wr(12'h104, {8'h81, 8'h00, crc8(16'hFFFF, 8'h02)});
        wr(12'h004, 32'h0000_0002);
        wr(12'h000, 32'h0000_0011);
        wold_partner_inst.send(48'h0000_0000_0004);
        repeat (3) @(posedge aclk);
        chk(remote_wakeup, 0);
        wold_partner_inst.send(48'h0000_0000_0002);
        wake_wait();
        rd(12'h00C, 32'h0000_0102, 2'h0);
        resume();
        rd(12'h004, 32'h0000_0202, 2'h0);
    endtask
    // watchdog
    initial
    begin
        #200us;
        n_fail++;
        test_done();
    end
    // main sequence
    initial
    begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, host_resume, stored} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        wstrb = 4'hF;
        n_fail = 0;
        total_checks = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_exact();
        t_pattern();
        test_done();
    end
endmodule : wold_top_tb_top
`default_nettype wire
